// File: src/byte_dma_controller.sv
// Operation
// - Byte space is 256 pages of 16K bytes, reached only by this engine.
// - Byte data travels on external data lines 15 to 8.
// - 22-bit byte address: page on data 23:16, offset on address 13:0.
// - Each byte access is stretched by the 4-bit wait field and mode bit.
// - Engine runs beside the core, stealing one core cycle per word.
// - Format 00 PM 24-bit, 01 DM 16-bit, 10 DM upper byte, 11 DM lower byte.
// - Each word uses as many consecutive byte accesses as its size needs.
// - Eight-bit formats fill the unused half of the DM word with zeros.
// - Start from internal address, 14-bit external offset and 8-bit page.
// - Direction picks byte memory to on-chip or on-chip to byte memory.
// - Writing nonzero word count starts; accesses run until count is zero.
// - Count drops after each word; at zero the transfer ends, interrupt raised.
// - Offset carries into page so transfers cross page boundaries.
// - Internal side is always on-chip program or data memory.
// - A completed word moves to or from on-chip memory in one cycle.
// - Core external accesses win over engine byte accesses.
// - Hold bit 0 lets core run; 1 halts core, restarts at zero when done.
// - Overlay selection bits should stay zero so base blocks are used.
// - Composite select follows each enabled individual select, same timing; the byte term here uses the engine strobes, not the byte select.
// - Reset enables all composite bits except byte; byte select starts enabled.
// - Boot reset clears setup, selects PM 24-bit, count 32, hold set.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "byte_dma_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module byte_dma_controller #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr_in,
  input  wire logic                 s_axi_awvalid_in,
  output logic                      s_axi_awready_out,
  input  wire logic [31:0]          s_axi_wdata_in,
  input  wire logic [3:0]           s_axi_wstrb_in,
  input  wire logic                 s_axi_wvalid_in,
  output logic                      s_axi_wready_out,
  output logic [1:0]                s_axi_bresp_out,
  output logic                      s_axi_bvalid_out,
  input  wire logic                 s_axi_bready_in,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr_in,
  input  wire logic                 s_axi_arvalid_in,
  output logic                      s_axi_arready_out,
  output logic [31:0]               s_axi_rdata_out,
  output logic [1:0]                s_axi_rresp_out,
  output logic                      s_axi_rvalid_out,
  input  wire logic                 s_axi_rready_in,
  input  wire logic                 boot_select_in,
  input  wire logic                 core_ext_req_in,
  input  wire logic                 bus_grant_in,
  input  wire logic                 program_space_select_n_in,
  input  wire logic                 data_space_select_n_in,
  input  wire logic                 io_space_select_n_in,
  output logic                      mem_req_out,
  output logic                      mem_write_out,
  output logic                      mem_program_out,
  output logic [13:0]               mem_addr_out,
  output logic [23:0]               mem_wdata_out,
  input  wire logic [23:0]          mem_rdata_in,
  output logic                      core_steal_out,
  output logic                      core_hold_out,
  output logic                      core_restart_out,
  output logic                      irq_request_out,
  input  wire logic                 irq_ack_in,
  output logic [13:0]               ext_addr_out,
  output logic [23:0]               ext_data_out,
  output logic [23:0]               ext_data_oe_out,
  input  wire logic [7:0]           ext_byte_data_in,
  output logic                      ext_rd_n_out,
  output logic                      ext_wr_n_out,
  output logic                      byte_space_select_n_out,
  output logic                      composite_select_n_out
);
  import byte_dma_pkg::*;

  // Bytes per word for a format
  function automatic logic [1:0] bytes_per_word(input logic [1:0] fmt);
    case (fmt)
      FMT_PM24: bytes_per_word = 2'h3;
      FMT_DM16: bytes_per_word = 2'h2;
      default:  bytes_per_word = 2'h1;
    endcase
  endfunction : bytes_per_word

  // Strobe length in cycles; reads add the pin synchroniser depth
  function automatic logic [4:0] strobe_cycles(input logic [3:0] w, input logic m,
                                               input logic rd);
    logic [4:0] waits;
    waits = m ? ({w, 1'b1} > `MAX_WAITS ? `MAX_WAITS : {w, 1'b1}) : {1'b0, w};
    strobe_cycles = waits + 5'h01 + (rd ? `SYNC_STAGES : 5'h00);
  endfunction : strobe_cycles

  // Merge a write under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : merge

  // Register state
  logic [1:0]  fmt_q;
  logic        dir_q;
  logic        hold_q;
  logic [3:0]  ovl_q;
  logic [7:0]  page_q;
  logic [13:0] int_addr_q;
  logic [13:0] ext_off_q;
  logic [13:0] count_q;
  logic [3:0]  wait_q;
  logic        wmode_q;
  logic [3:0]  cms_en_q;
  logic        byte_sel_en_q;
  logic        irq_q;
  logic        busy_q;

  // AXI state
  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_have_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              w_have_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // Engine state
  dma_state_e  state_q;
  logic [1:0]  bytes_left_q;
  logic [4:0]  acc_cnt_q;
  logic [23:0] word_q;
  logic        sel_n_q;
  logic        rd_n_q;
  logic        wr_n_q;
  logic [23:0] data_oe_q;
  logic [7:0]  byte_out_q;
  logic        restart_q;

  // Pin synchronisers and boot start-up
  logic [7:0]  byte_s1_q;
  logic [7:0]  byte_s2_q;
  logic        strap_s1_q;
  logic        strap_s2_q;
  logic [1:0]  init_cnt_q;
  logic        boot_load;

  // AXI write path
  logic        wr_fire;
  logic [31:0] wr_val;
  logic        wr_hit;
  logic        wr_ctl;
  logic        wr_int;
  logic        wr_ext;
  logic        wr_cnt;
  logic        wr_sts;
  logic        wr_wait;
  logic        wr_cms;
  logic        start_req;

  // Engine events
  logic        strobe_end;
  logic        word_done;
  logic        last_word;
  logic        finish;

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_val  = merge(32'h0000_0000, w_data_q, w_strb_q);

  always_comb begin
    wr_ctl  = 1'b0;
    wr_int  = 1'b0;
    wr_ext  = 1'b0;
    wr_cnt  = 1'b0;
    wr_sts  = 1'b0;
    wr_wait = 1'b0;
    wr_cms  = 1'b0;
    wr_hit  = 1'b1;
    case ({aw_addr_q[ADDR_W-1:2], 2'h0})
      `OFS_CONTROL:        wr_ctl  = wr_fire;
      `OFS_INTERNAL_START: wr_int  = wr_fire;
      `OFS_EXTERNAL_START: wr_ext  = wr_fire;
      `OFS_WORD_COUNT:     wr_cnt  = wr_fire;
      `OFS_STATUS:         wr_sts  = wr_fire;
      `OFS_WAIT_CONTROL:   wr_wait = wr_fire;
      `OFS_COMPOSITE:      wr_cms  = wr_fire;
      default:             wr_hit  = 1'b0;
    endcase
  end

  // Transfer setup is locked while the engine runs
  assign start_req = wr_cnt && !busy_q && (wr_val[13:0] != 14'h0000);

  assign s_axi_awready_out = !aw_have_q && !bvalid_q;
  assign s_axi_wready_out  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid_out  = bvalid_q;
  assign s_axi_bresp_out   = bresp_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out  = rvalid_q;
  assign s_axi_rdata_out   = rdata_q;
  assign s_axi_rresp_out   = rresp_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_addr_q <= '0;
      aw_have_q <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr_q <= s_axi_awaddr_in;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
        w_have_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `RESP_OKAY;
      case ({s_axi_araddr_in[ADDR_W-1:2], 2'h0})
        `OFS_CONTROL:        rdata_q <= {16'h0000, page_q, ovl_q, hold_q, dir_q, fmt_q};
        `OFS_INTERNAL_START: rdata_q <= {18'h00000, int_addr_q};
        `OFS_EXTERNAL_START: rdata_q <= {18'h00000, ext_off_q};
        `OFS_WORD_COUNT:     rdata_q <= {18'h00000, count_q};
        `OFS_STATUS:         rdata_q <= {30'h0000_0000, busy_q, irq_q};
        `OFS_WAIT_CONTROL:   rdata_q <= {27'h000_0000, wmode_q, wait_q};
        `OFS_COMPOSITE:      rdata_q <= {23'h00_0000, byte_sel_en_q, 4'h0, cms_en_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  // Boot strap caught after reset release through two flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
      init_cnt_q <= 2'h0;
    end else begin
      strap_s1_q <= boot_select_in;
      strap_s2_q <= strap_s1_q;
      if (init_cnt_q != 2'h3) begin
        init_cnt_q <= init_cnt_q + 2'h1;
      end
    end
  end
  assign boot_load = (init_cnt_q == `BOOT_INIT_CYCLE) && strap_s2_q;

  // Transfer configuration
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fmt_q         <= 2'h0;
      dir_q         <= 1'b0;
      hold_q        <= 1'b0;
      ovl_q         <= 4'h0;
      wait_q        <= 4'h0;
      wmode_q       <= 1'b0;
      cms_en_q      <= `CMS_RESET;
      byte_sel_en_q <= `BYTE_SEL_EN_RESET;
    end else begin
      if (boot_load) begin
        fmt_q  <= FMT_PM24;
        dir_q  <= 1'b0;
        hold_q <= 1'b1;
        ovl_q  <= 4'h0;
      end else if (wr_ctl && !busy_q) begin
        fmt_q  <= wr_val[`CTL_FORMAT_LSB +: 2];
        dir_q  <= wr_val[`CTL_DIR_BIT];
        hold_q <= wr_val[`CTL_HOLD_BIT];
        ovl_q  <= wr_val[`CTL_OVL_LSB +: 4];
      end
      if (wr_wait) begin
        wait_q  <= wr_val[`WAIT_COUNT_LSB +: 4];
        wmode_q <= wr_val[`WAIT_MODE_BIT];
      end
      if (wr_cms) begin
        cms_en_q      <= wr_val[3:0];
        byte_sel_en_q <= wr_val[`BYTE_SEL_EN_BIT];
      end
    end
  end

  // Live addresses and count; these double as the progress registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      page_q     <= 8'h00;
      int_addr_q <= 14'h0000;
      ext_off_q  <= 14'h0000;
      count_q    <= 14'h0000;
    end else if (boot_load) begin
      page_q     <= 8'h00;
      int_addr_q <= 14'h0000;
      ext_off_q  <= 14'h0000;
      count_q    <= `BOOT_WORD_COUNT;
    end else begin
      if (wr_ctl && !busy_q) begin
        page_q <= wr_val[`CTL_PAGE_LSB +: 8];
      end
      if (wr_int && !busy_q) begin
        int_addr_q <= wr_val[13:0];
      end
      if (wr_ext && !busy_q) begin
        ext_off_q <= wr_val[13:0];
      end
      if (wr_cnt && !busy_q) begin
        count_q <= wr_val[13:0];
      end
      if (strobe_end) begin
        {page_q, ext_off_q} <= {page_q, ext_off_q} + 22'h00_0001;
      end
      if (word_done) begin
        int_addr_q <= int_addr_q + 14'h0001;
        count_q    <= count_q - 14'h0001;
      end
    end
  end

  // Completion request, set wins over acknowledge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_q <= 1'b0;
    end else if (finish) begin
      irq_q <= 1'b1;
    end else if (irq_ack_in || (wr_sts && wr_val[`STS_IRQ_BIT])) begin
      irq_q <= 1'b0;
    end
  end

  // Byte data pins pass two flops before use
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byte_s1_q <= 8'h00;
      byte_s2_q <= 8'h00;
    end else begin
      byte_s1_q <= ext_byte_data_in;
      byte_s2_q <= byte_s1_q;
    end
  end

  assign strobe_end = (state_q == S_STROBE) && (acc_cnt_q == 5'h00);
  assign last_word  = (count_q == 14'h0001);
  assign word_done  = (state_q == S_STORE) ||
                      (strobe_end && dir_q && (bytes_left_q == 2'h1));
  assign finish     = word_done && last_word;

  // Transfer engine
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q      <= S_IDLE;
      busy_q       <= 1'b0;
      bytes_left_q <= 2'h0;
      acc_cnt_q    <= 5'h00;
      word_q       <= 24'h00_0000;
      sel_n_q      <= 1'b1;
      rd_n_q       <= 1'b1;
      wr_n_q       <= 1'b1;
      data_oe_q    <= 24'h00_0000;
      byte_out_q   <= 8'h00;
      restart_q    <= 1'b0;
    end else begin
      restart_q <= finish && hold_q;
      if (boot_load || start_req) begin
        busy_q <= 1'b1;
      end else if (finish) begin
        busy_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (busy_q) begin
            bytes_left_q <= bytes_per_word(fmt_q);
            state_q      <= dir_q ? S_FETCH : S_ARB;
          end
        end
        S_FETCH: state_q <= S_LATCH;
        S_LATCH: begin
          case (fmt_q)
            FMT_PM24:    word_q <= mem_rdata_in;
            FMT_DM16:    word_q <= {mem_rdata_in[15:0], 8'h00};
            FMT_DM8_MSB: word_q <= {mem_rdata_in[15:8], 16'h0000};
            default:     word_q <= {mem_rdata_in[7:0], 16'h0000};
          endcase
          state_q <= S_ARB;
        end
        S_ARB: begin
          // Core external cycles and a granted bus both keep the engine off the pins
          if (!core_ext_req_in && !bus_grant_in) begin
            acc_cnt_q  <= strobe_cycles(wait_q, wmode_q, !dir_q) - 5'h01;
            sel_n_q    <= !byte_sel_en_q;
            rd_n_q     <= dir_q;
            wr_n_q     <= !dir_q;
            byte_out_q <= word_q[23:16];
            data_oe_q  <= {8'hFF, dir_q ? 8'hFF : 8'h00, 8'h00};
            state_q    <= S_STROBE;
          end
        end
        S_STROBE: begin
          if (acc_cnt_q == 5'h00) begin
            sel_n_q      <= 1'b1;
            rd_n_q       <= 1'b1;
            wr_n_q       <= 1'b1;
            data_oe_q    <= 24'h00_0000;
            bytes_left_q <= bytes_left_q - 2'h1;
            word_q       <= dir_q ? {word_q[15:0], 8'h00} : {word_q[15:0], byte_s2_q};
            if (bytes_left_q != 2'h1) begin
              state_q <= S_ARB;
            end else if (!dir_q) begin
              state_q <= S_STORE;
            end else begin
              bytes_left_q <= bytes_per_word(fmt_q);
              state_q      <= last_word ? S_IDLE : S_FETCH;
            end
          end else begin
            acc_cnt_q <= acc_cnt_q - 5'h01;
          end
        end
        S_STORE: begin
          bytes_left_q <= bytes_per_word(fmt_q);
          state_q      <= last_word ? S_IDLE : S_ARB;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // On-chip side, one cycle per word
  assign mem_req_out     = (state_q == S_FETCH) || (state_q == S_STORE);
  assign mem_write_out   = (state_q == S_STORE);
  assign mem_program_out = (fmt_q == FMT_PM24);
  assign mem_addr_out    = int_addr_q;
  assign core_steal_out  = mem_req_out;
  assign core_hold_out   = busy_q && hold_q;
  assign core_restart_out = restart_q;
  assign irq_request_out = irq_q;

  always_comb begin
    case (fmt_q)
      FMT_PM24:    mem_wdata_out = word_q;
      FMT_DM16:    mem_wdata_out = {8'h00, word_q[15:0]};
      FMT_DM8_MSB: mem_wdata_out = {8'h00, word_q[7:0], 8'h00};
      default:     mem_wdata_out = {16'h0000, word_q[7:0]};
    endcase
  end

  // External byte space pins
  assign ext_addr_out            = ext_off_q;
  assign ext_data_out            = {page_q, byte_out_q, 8'h00};
  assign ext_data_oe_out         = bus_grant_in ? 24'h00_0000 : data_oe_q;
  assign ext_rd_n_out            = rd_n_q;
  assign ext_wr_n_out            = wr_n_q;
  assign byte_space_select_n_out = sel_n_q;
  // Composite follows the enabled selects, and the byte strobes in place of the byte select, combinationally so its timing matches
  assign composite_select_n_out  = !((cms_en_q[0] && !program_space_select_n_in) ||
                                     (cms_en_q[1] && !data_space_select_n_in) ||
                                     (cms_en_q[`CMS_BYTE_BIT] && !rd_n_q) ||
                                     (cms_en_q[`CMS_BYTE_BIT] && !wr_n_q) ||
                                     (cms_en_q[3] && !io_space_select_n_in));
endmodule : byte_dma_controller
`default_nettype wire

// File: src/byte_dma_cfg.svh
`ifndef BYTE_DMA_CFG_SVH
`define BYTE_DMA_CFG_SVH

// Register byte offsets
`define OFS_CONTROL        8'h00
`define OFS_INTERNAL_START 8'h04
`define OFS_EXTERNAL_START 8'h08
`define OFS_WORD_COUNT     8'h0C
`define OFS_STATUS         8'h10
`define OFS_WAIT_CONTROL   8'h14
`define OFS_COMPOSITE      8'h18

// Control register fields
`define CTL_FORMAT_LSB     0
`define CTL_DIR_BIT        2
`define CTL_HOLD_BIT       3
`define CTL_OVL_LSB        4
`define CTL_PAGE_LSB       8

// Status register fields
`define STS_IRQ_BIT        0
`define STS_BUSY_BIT       1

// Wait control fields
`define WAIT_COUNT_LSB     0
`define WAIT_MODE_BIT      4

// Composite select enables: bit0 program, bit1 data, bit2 byte, bit3 io
`define CMS_BYTE_BIT       2
`define CMS_RESET          4'hB
`define BYTE_SEL_EN_BIT    8
`define BYTE_SEL_EN_RESET  1'b1

// Boot defaults and timing
`define BOOT_WORD_COUNT    14'h0020
`define BOOT_INIT_CYCLE    2'h2
`define SYNC_STAGES        5'h02
`define MAX_WAITS          5'h0F

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// File: src/byte_dma_pkg.sv
package byte_dma_pkg;
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_LATCH, S_ARB, S_STROBE, S_STORE} dma_state_e;
  typedef enum logic [1:0] {
    FMT_PM24    = 2'h0,
    FMT_DM16    = 2'h1,
    FMT_DM8_MSB = 2'h2,
    FMT_DM8_LSB = 2'h3
  } transfer_format_e;
endpackage : byte_dma_pkg

// File: tb/byte_dma_controller_properties.sv
`timescale 1ns/1ps
`default_nettype none
module byte_dma_checker (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        core_ext_req_in,
  input wire logic        program_space_select_n_in,
  input wire logic        mem_req_out,
  input wire logic        core_steal_out,
  input wire logic        core_hold_out,
  input wire logic        core_restart_out,
  input wire logic        irq_request_out,
  input wire logic        irq_ack_in,
  input wire logic [23:0] ext_data_oe_out,
  input wire logic        ext_rd_n_out,
  input wire logic        ext_wr_n_out,
  input wire logic        composite_select_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire strobe = !ext_rd_n_out || !ext_wr_n_out;
  a_steal_one_cycle: assert property (mem_req_out |-> core_steal_out ##1 !mem_req_out)
    else $error("core steal not one cycle");
  a_rd_wr_excl: assert property (!(!ext_rd_n_out && !ext_wr_n_out))
    else $error("read and write strobes together");
  a_page_drive: assert property (strobe |-> &ext_data_oe_out[23:16])
    else $error("page lines not driven");
  a_data_lanes: assert property (strobe |-> ext_data_oe_out[15:8] == {8{!ext_wr_n_out}})
    else $error("data lane enable wrong");
  a_core_first: assert property (core_ext_req_in && !strobe |=> !strobe)
    else $error("byte access started over core");
  a_comp_follow: assert property (!program_space_select_n_in |-> !composite_select_n_out)
    else $error("composite select missed");
  a_irq_latched: assert property (irq_request_out && !irq_ack_in |=> irq_request_out || s_axi_bvalid_out)
    else $error("interrupt dropped");
  a_restart_pulse: assert property ($rose(core_restart_out) |-> $past(core_hold_out) ##1 !core_restart_out)
    else $error("restart pulse wrong");
  a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped");
  c_irq: cover property ($rose(irq_request_out));
  c_restart: cover property (core_restart_out);
  c_comp: cover property (!composite_select_n_out);
endmodule : byte_dma_checker
bind byte_dma_controller byte_dma_checker u_chk (.clk_in, .reset_n_in, .s_axi_bvalid_out,
  .s_axi_bready_in, .core_ext_req_in, .program_space_select_n_in, .mem_req_out,
  .core_steal_out, .core_hold_out, .core_restart_out, .irq_request_out, .irq_ack_in,
  .ext_data_oe_out, .ext_rd_n_out, .ext_wr_n_out, .composite_select_n_out);
`default_nettype wire

// File: tb/byte_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module byte_mem_model (
  input  wire logic        clk_in,
  input  wire logic [13:0] ext_addr_in,
  input  wire logic [23:0] ext_data_in,
  input  wire logic        ext_rd_n_in,
  input  wire logic        ext_wr_n_in,
  input  wire logic        select_n_in,
  output logic [7:0]       byte_out
);
  logic [7:0]  mem [int];
  logic [7:0]  last_q = 8'h00;
  wire  [21:0] addr = {ext_data_in[23:16], ext_addr_in};
  function automatic logic [7:0] peek(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[21:14];
  endfunction : peek
  // Sampled on the clock so an address change at the strobe's end is not written
  always @(posedge clk_in) begin
    if (!ext_wr_n_in && !select_n_in) mem[addr] = ext_data_in[15:8];
    if (!ext_rd_n_in && !select_n_in) last_q <= peek(addr);
  end
  // Released lines show the inverse, never a stale byte
  assign byte_out = (!ext_rd_n_in && !select_n_in) ? peek(addr) : ~last_q;
endmodule : byte_mem_model
`default_nettype wire

// File: tb/byte_dma_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module byte_dma_controller_tb;
  logic clk_in = 0, reset_n_in = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, core_req = 0, pss_n = 1, ack = 0, gnt = 0, dss_n = 1;
  logic [7:0] awaddr = 0, araddr = 0, ebyte;
  logic [31:0] wdata = 0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, mreq, mwr, mprog;
  logic erd_n, ewr_n, bsel_n, csel_n, hold, restart, irq;
  logic [1:0] bresp, rresp, r;
  logic [13:0] maddr, eaddr;
  logic [23:0] mwdata, mrdata = 0, edata, eoe;
  logic [24:0] om [int];
  int err_count = 0, n_tests = 0, wlow;
  bit held, restarted;
  always #2 clk_in = ~clk_in;
  byte_dma_controller dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .boot_select_in(1'b0),
    .core_ext_req_in(core_req), .bus_grant_in(gnt), .program_space_select_n_in(pss_n),
    .data_space_select_n_in(dss_n), .io_space_select_n_in(1'b1), .mem_req_out(mreq),
    .mem_write_out(mwr), .mem_program_out(mprog), .mem_addr_out(maddr),
    .mem_wdata_out(mwdata), .mem_rdata_in(mrdata), .core_steal_out(),
    .core_hold_out(hold), .core_restart_out(restart), .irq_request_out(irq),
    .irq_ack_in(ack), .ext_addr_out(eaddr), .ext_data_out(edata), .ext_data_oe_out(eoe),
    .ext_byte_data_in(ebyte), .ext_rd_n_out(erd_n), .ext_wr_n_out(ewr_n),
    .byte_space_select_n_out(bsel_n), .composite_select_n_out(csel_n));
  byte_mem_model u_mem (.clk_in(clk_in), .ext_addr_in(eaddr), .ext_data_in(edata),
    .ext_rd_n_in(erd_n), .ext_wr_n_in(ewr_n), .select_n_in(bsel_n), .byte_out(ebyte));
  // On-chip memory: read data stands in the cycle after the request
  always @(posedge clk_in) begin
    mrdata <= 24'hA5C300 ^ {10'h0, maddr};
    if (mreq && mwr) om[maddr] = {mprog, mwdata};
    held |= hold;
    restarted |= restart;
    if (!ewr_n) wlow++;
  end
  function automatic logic [7:0] bval(input logic [21:0] a);
    return a[7:0] ^ a[21:14];
  endfunction : bval
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    repeat (40) begin
      @(negedge clk_in);
      ta = awready; tw = wready; tb = bvalid;
      @(posedge clk_in);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) begin
        return;
      end
    end
    err_count++;
    wrap_up();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tv;
    araddr <= a; arvalid <= 1; rready <= 1;
    repeat (40) begin
      @(negedge clk_in);
      ta = arready; tv = rvalid; d = rdata; r = rresp;
      @(posedge clk_in);
      if (ta) arvalid <= 0;
      if (tv) begin
        return;
      end
    end
    err_count++;
    wrap_up();
  endtask : rd
  task automatic run(input logic [15:0] ctl, input logic [13:0] ia, ea, n);
    wr(8'h00, 32'(ctl)); wr(8'h04, 32'(ia)); wr(8'h08, 32'(ea)); wr(8'h0C, 32'(n));
    repeat (3000) begin
      @(negedge clk_in);
      if (irq === 1'b1) break;
    end
    chk("irq", 32'(irq), 1);
    @(posedge clk_in);
    ack <= 1;
    @(posedge clk_in);
    ack <= 0;
    @(negedge clk_in);
    chk("irq ack", 32'(irq), 0);
    @(posedge clk_in);
    rd(8'h0C);
    chk("count", d, 0);
  endtask : run
  task automatic t_regs();
    rd(8'h18);
    chk("cms reset", d, 32'h0000010B);
    rd(8'h1C);
    chk("unmapped", 32'(r), 32'h2);
    $display("done regs");
  endtask : t_regs
  task automatic t_fmt();
    logic [24:0] e;
    logic [13:0] ea;
    for (int f = 0; f < 4; f++) begin
      ea = 14'(f * 8);
      case (f)
        0: e = {1'b1, bval(22'(ea)), bval(22'(ea + 1)), bval(22'(ea + 2))};
        1: e = {9'h0, bval(22'(ea)), bval(22'(ea + 1))};
        2: e = {9'h0, bval(22'(ea)), 8'h00};
        default: e = {17'h0, bval(22'(ea))};
      endcase
      run(16'(f), 14'(32 + f), ea, 14'h1);
      chk("fmt word", om[32 + f], 32'(e));
      rd(8'h04);
      chk("int addr", d, 32'(33 + f));
      rd(8'h08);
      chk("ext offset", d, 32'(ea) + (f == 0 ? 3 : f == 1 ? 2 : 1));
    end
    $display("done formats");
  endtask : t_fmt
  task automatic t_cross();
    wr(8'h14, 32'h0);
    run(16'h0301, 14'h10, 14'h3FFF, 14'h2);
    chk("cross w0", om[16], {16'h0, bval(22'h00FFFF), bval(22'h010000)});
    chk("cross w1", om[17], {16'h0, bval(22'h010001), bval(22'h010002)});
    rd(8'h00);
    chk("page", 32'(d[15:8]), 32'h4);
    $display("done crossing");
  endtask : t_cross
  task automatic t_out();
    wr(8'h14, 32'h3);
    held = 0; restarted = 0; wlow = 0; core_req <= 1;
    fork
      run(16'h070D, 14'h5, 14'h100, 14'h1);
      begin
        repeat (30) @(posedge clk_in);
        core_req <= 0;
      end
    join
    chk("byte hi", 32'(u_mem.peek(22'h01C100)), 32'hC3);
    chk("byte lo", 32'(u_mem.peek(22'h01C101)), 32'h05);
    chk("wait cycles", 32'(wlow), 32'd8);
    chk("hold seen", 32'(held), 1);
    chk("restart seen", 32'(restarted), 1);
    $display("done outbound");
  endtask : t_out
  task automatic t_comp();
    pss_n <= 0;
    @(negedge clk_in);
    chk("composite", 32'(csel_n), 0);
    @(posedge clk_in);
    pss_n <= 1; dss_n <= 0;
    @(negedge clk_in);
    chk("composite dm", 32'(csel_n), 0);
    @(posedge clk_in);
    dss_n <= 1;
    $display("done composite");
  endtask : t_comp
  initial begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1;
    @(posedge clk_in);
    t_regs();
    t_fmt();
    t_cross();
    t_out();
    t_comp();
    wrap_up();
  end
endmodule : byte_dma_controller_tb
`default_nettype wire
